// File: hdl/csc_slot_ctrl.sv
// Purpose: Card slot control and status signals with Wishbone registers
// Assumes: All inputs synchronous to clk_i
// Notes: Card strobes carried as one active-low strobe output
`timescale 1ns/100ps
// Function
// - Attribute select low for attribute memory, high for common memory.
// - Attribute select held low throughout ordinary I/O cycles.
// - Attribute select held high in DMA transfer cycles except while wait holds an I/O strobe.
// - In DMA mode attribute select acts as card DMA acknowledge.
// - Card flags 16-bit I/O port; outside DMA mode device sizes that cycle 16-bit.
// - Write-protect pin: switch for memory, 16-bit flag for I/O, DMA request.
// - Outside DMA mode, with input-acknowledge enabled, I/O read data passes only while acknowledged.
// - In DMA mode DMA request may come from input-acknowledge pin.
// - Ready/busy pin is ready status for memory, interrupt request for I/O.
// - Card wait stretches cycle; strobes stay active until wait released.
// - Card detect sensed even with slot power off.
// - High reset-drive input is a cold reset of all logic.
// - Card speaker signal of a present I/O card passes to speaker output.
// - Card ring-indicate signal of a present I/O card passes to ring-indicate output.
// - Enabled general-purpose input raises an interrupt on transitions.
// - Separate active-low 5V and 3.3V enables plus two programming controls.
// - Interrupt output pulses low three clocks per request, else high.
module csc_slot_ctrl
  import csc_pkg::*;
(
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reset_drive_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic int_o,
  // Card cycle request from the mapping logic
  input wire logic cyc_req_i,
  input wire logic cyc_attr_i,
  input wire logic cyc_io_i,
  input wire logic cyc_rd_i,
  input wire logic [15:0] cyc_rdata_i,
  output logic cyc_done_o,
  output logic cyc_16bit_o,
  output logic [15:0] cyc_rdata_o,
  output logic cyc_rdata_valid_o,
  output logic dma_req_o,
  // Card side
  input wire logic card_detect1_n_i,
  input wire logic card_detect2_n_i,
  input wire logic ready_busy_i,
  input wire logic wait_n_i,
  input wire logic write_protect_i,
  input wire logic inpack_n_i,
  input wire logic speaker_n_i,
  input wire logic ring_n_i,
  output logic attr_sel_n_o,
  output logic card_strobe_n_o,
  // System side
  input wire logic volt_detect_gp_input_i,
  input wire logic power_ok_input_i,
  output logic speaker_pass_out_n_o,
  output logic ring_indicate_out_n_o,
  output logic irq_pulse_out_n_o,
  output logic slot_supply_high_en_n_o,
  output logic slot_supply_low_en_n_o,
  output logic prog_supply_ctl_a_o,
  output logic prog_supply_ctl_b_o
);
  logic rst;
  logic [CSC_CTRL_W-1:0] ctrl_q;
  logic [CSC_EVT_W-1:0] evt_q;
  logic [CSC_EVT_W-1:0] mask_q;
  logic [CSC_EVT_W-1:0] evt_set;
  logic present_q;
  logic ready_q;
  logic gpi_q;
  logic [1:0] pulse_cnt_q;
  csc_state_t state_q;
  csc_acc_t acc_q;
  logic wb_req;
  logic wb_wr;
  logic card_present;
  logic io_card;
  logic dma_mode;
  logic irq_req;

  assign rst = rst_i | reset_drive_i;
  assign io_card = ctrl_q[CSC_CTRL_IOCARD];
  assign dma_mode = ctrl_q[CSC_CTRL_DMA];

  assign card_present = ~card_detect1_n_i & ~card_detect2_n_i;

  // Wishbone access, one wait state then ack
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req) begin
      if (wb_adr_i == CSC_OFS_CTRL) begin
        wb_dat_o <= {24'h00_0000, ctrl_q};
      end else if (wb_adr_i == CSC_OFS_STAT) begin
        wb_dat_o <= {26'h000_0000, power_ok_input_i, ~volt_detect_gp_input_i,
                     write_protect_i, ready_busy_i, card_detect2_n_i, present_q};
      end else if (wb_adr_i == CSC_OFS_EVT) begin
        wb_dat_o <= {29'h0000_0000, evt_q};
      end else if (wb_adr_i == CSC_OFS_MASK) begin
        wb_dat_o <= {29'h0000_0000, mask_q};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst) begin
      ctrl_q <= CSC_CTRL_RST;
    end else if (wb_wr && wb_adr_i == CSC_OFS_CTRL) begin
      ctrl_q <= wb_dat_i[CSC_CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst) begin
      mask_q <= 3'h0;
    end else if (wb_wr && wb_adr_i == CSC_OFS_MASK) begin
      mask_q <= wb_dat_i[CSC_EVT_W-1:0];
    end
  end

  // Input history for edge events
  always_ff @(posedge clk_i) begin
    if (rst) begin
      present_q <= 1'b0;
      ready_q <= 1'b1;
      gpi_q <= 1'b1;
    end else begin
      present_q <= card_present;
      ready_q <= ready_busy_i;
      gpi_q <= volt_detect_gp_input_i;
    end
  end

  always_comb begin
    evt_set = '0;
    evt_set[CSC_EVT_DETECT] = card_present ^ present_q;
    // Falling request line of an I/O card
    evt_set[CSC_EVT_READY] = io_card ? (ready_q & ~ready_busy_i) : (~ready_q & ready_busy_i);
    evt_set[CSC_EVT_GPI] = ctrl_q[CSC_CTRL_GPI_EN] & (gpi_q ^ volt_detect_gp_input_i);
  end

  // Sticky events, set wins over write-one clear
  always_ff @(posedge clk_i) begin
    if (rst) begin
      evt_q <= 3'h0;
    end else if (wb_wr && wb_adr_i == CSC_OFS_EVT) begin
      evt_q <= (evt_q & ~wb_dat_i[CSC_EVT_W-1:0]) | evt_set;
    end else begin
      evt_q <= evt_q | evt_set;
    end
  end

  assign int_o = |(evt_q & mask_q);
  assign irq_req = |(evt_set & mask_q);

  always_ff @(posedge clk_i) begin
    if (rst) begin
      pulse_cnt_q <= 2'h0;
    end else if (irq_req && pulse_cnt_q == 2'h0) begin
      pulse_cnt_q <= CSC_IRQ_PULSE_CYC;
    end else if (pulse_cnt_q != 2'h0) begin
      pulse_cnt_q <= pulse_cnt_q - 2'h1;
    end
  end
  assign irq_pulse_out_n_o = (pulse_cnt_q == 2'h0);

  // Card cycle sequencer
  always_ff @(posedge clk_i) begin
    if (rst) begin
      state_q <= CSC_ST_IDLE;
      acc_q <= CSC_ACC_COMMON;
    end else begin
      case (state_q)
        CSC_ST_IDLE: begin
          if (cyc_req_i && card_present) begin
            state_q <= CSC_ST_STROBE;
            acc_q <= cyc_io_i ? CSC_ACC_IO : (cyc_attr_i ? CSC_ACC_ATTR : CSC_ACC_COMMON);
          end
        end
        CSC_ST_STROBE: begin
          if (wait_n_i) begin
            state_q <= CSC_ST_DONE;
          end
        end
        CSC_ST_DONE: begin
          state_q <= CSC_ST_IDLE;
        end
        default: begin
          state_q <= CSC_ST_IDLE;
        end
      endcase
    end
  end

  assign card_strobe_n_o = (state_q != CSC_ST_STROBE);
  assign cyc_done_o = (state_q == CSC_ST_DONE);

  // Attribute select
  always_ff @(posedge clk_i) begin
    if (rst) begin
      attr_sel_n_o <= 1'b1;
    end else if (dma_mode) begin
      // Low attribute select acts as DMA acknowledge
      attr_sel_n_o <= ~(state_q == CSC_ST_STROBE && !wait_n_i && acc_q == CSC_ACC_IO);
    end else if (state_q == CSC_ST_IDLE && cyc_req_i && card_present) begin
      attr_sel_n_o <= ~(cyc_io_i | cyc_attr_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst) begin
      cyc_16bit_o <= 1'b0;
    end else begin
      cyc_16bit_o <= io_card & ~dma_mode & ~write_protect_i & (acc_q == CSC_ACC_IO);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst) begin
      cyc_rdata_o <= 16'h0000;
      cyc_rdata_valid_o <= 1'b0;
    end else begin
      cyc_rdata_valid_o <= 1'b0;
      if (state_q == CSC_ST_STROBE && wait_n_i && cyc_rd_i && acc_q == CSC_ACC_IO
          && (!ctrl_q[CSC_CTRL_INPACK_EN] || dma_mode || !inpack_n_i)) begin
        cyc_rdata_o <= cyc_rdata_i;
        cyc_rdata_valid_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst) begin
      dma_req_o <= 1'b0;
    end else begin
      dma_req_o <= dma_mode & (ctrl_q[CSC_CTRL_INPACK_EN] ? ~inpack_n_i : write_protect_i);
    end
  end

  // Pass-through of card audio and ring
  always_ff @(posedge clk_i) begin
    if (rst) begin
      speaker_pass_out_n_o <= 1'b1;
      ring_indicate_out_n_o <= 1'b1;
    end else begin
      speaker_pass_out_n_o <= ~(io_card & card_present & ~speaker_n_i);
      ring_indicate_out_n_o <= ~(io_card & card_present & ~ring_n_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst) begin
      slot_supply_high_en_n_o <= 1'b1;
      slot_supply_low_en_n_o <= 1'b1;
      prog_supply_ctl_a_o <= 1'b0;
      prog_supply_ctl_b_o <= 1'b0;
    end else begin
      slot_supply_high_en_n_o <= ~ctrl_q[CSC_CTRL_VCC5];
      slot_supply_low_en_n_o <= ~(ctrl_q[CSC_CTRL_VCC3] & ~ctrl_q[CSC_CTRL_VCC5]);
      prog_supply_ctl_a_o <= ctrl_q[CSC_CTRL_VPP_VCC];
      prog_supply_ctl_b_o <= ctrl_q[CSC_CTRL_VPP_PGM] & ~ctrl_q[CSC_CTRL_VPP_VCC];
    end
  end

  AST_IRQ_PULSE: assert property (@(posedge clk_i) disable iff (rst)
    $fell(irq_pulse_out_n_o) |-> !irq_pulse_out_n_o [*3] ##1 irq_pulse_out_n_o)
    else $error("interrupt pulse width wrong");
  AST_PRESENT: assert property (@(posedge clk_i) disable iff (rst)
    (card_detect1_n_i || card_detect2_n_i) |=> !present_q)
    else $error("card present with a detect high");
  AST_WAIT_HOLD: assert property (@(posedge clk_i) disable iff (rst)
    (state_q == CSC_ST_STROBE && !wait_n_i) |=> !card_strobe_n_o)
    else $error("strobe released during wait");
  AST_IO_ATTR_LOW: assert property (@(posedge clk_i) disable iff (rst)
    (!dma_mode && state_q == CSC_ST_STROBE && acc_q == CSC_ACC_IO) |-> !attr_sel_n_o)
    else $error("attribute select high in io cycle");
  AST_COMMON_HIGH: assert property (@(posedge clk_i) disable iff (rst)
    (!dma_mode && state_q == CSC_ST_STROBE && acc_q == CSC_ACC_COMMON) |-> attr_sel_n_o)
    else $error("attribute select low for common memory");
  AST_SPEAKER: assert property (@(posedge clk_i) disable iff (rst)
    (io_card && card_present && !speaker_n_i) |=> !speaker_pass_out_n_o)
    else $error("speaker not passed");
  AST_RING: assert property (@(posedge clk_i) disable iff (rst)
    (io_card && card_present && !ring_n_i) |=> !ring_indicate_out_n_o)
    else $error("ring not passed");
  AST_GPI_EVT: assert property (@(posedge clk_i) disable iff (rst)
    (ctrl_q[CSC_CTRL_GPI_EN] && $changed(volt_detect_gp_input_i)) |=> evt_q[CSC_EVT_GPI])
    else $error("gpi transition lost");
  AST_INPACK_GATE: assert property (@(posedge clk_i) disable iff (rst)
    (cyc_rdata_valid_o && ctrl_q[CSC_CTRL_INPACK_EN] && !dma_mode) |-> $past(!inpack_n_i))
    else $error("read data without acknowledge");
  AST_SUPPLY: assert property (@(posedge clk_i) disable iff (rst)
    ctrl_q[CSC_CTRL_VCC5] |=> !slot_supply_high_en_n_o && slot_supply_low_en_n_o)
    else $error("supply enables wrong");
  AST_DMA_HIGH: assert property (@(posedge clk_i) disable iff (rst)
    (dma_mode && state_q == CSC_ST_STROBE && wait_n_i) |=> attr_sel_n_o)
    else $error("attribute select low in dma transfer");
  AST_DMA_DACK: assert property (@(posedge clk_i) disable iff (rst)
    (dma_mode && state_q == CSC_ST_STROBE && !wait_n_i && acc_q == CSC_ACC_IO) |=> !attr_sel_n_o)
    else $error("dma acknowledge missing");
  AST_IO16: assert property (@(posedge clk_i) disable iff (rst)
    (io_card && !dma_mode && acc_q == CSC_ACC_IO && !write_protect_i) |=> cyc_16bit_o)
    else $error("io cycle not sized 16-bit");
endmodule : csc_slot_ctrl

// File: common/csc_pkg.sv
// Purpose: Constants for the card slot control block
// Assumes: Wishbone classic slave, 32-bit data, byte addresses
// Notes: Offsets are word aligned
package csc_pkg;
  // Register byte offsets
  localparam logic [7:0] CSC_OFS_CTRL = 8'h00;
  localparam logic [7:0] CSC_OFS_STAT = 8'h04;
  localparam logic [7:0] CSC_OFS_EVT = 8'h08;
  localparam logic [7:0] CSC_OFS_MASK = 8'h0C;
  // Control fields
  localparam int CSC_CTRL_IOCARD = 0;
  localparam int CSC_CTRL_DMA = 1;
  localparam int CSC_CTRL_INPACK_EN = 2;
  localparam int CSC_CTRL_GPI_EN = 3;
  localparam int CSC_CTRL_VCC5 = 4;
  localparam int CSC_CTRL_VCC3 = 5;
  localparam int CSC_CTRL_VPP_VCC = 6;
  localparam int CSC_CTRL_VPP_PGM = 7;
  localparam int CSC_CTRL_W = 8;
  localparam logic [CSC_CTRL_W-1:0] CSC_CTRL_RST = 8'h00;
  // Event bits
  localparam int CSC_EVT_DETECT = 0;
  localparam int CSC_EVT_READY = 1;
  localparam int CSC_EVT_GPI = 2;
  localparam int CSC_EVT_W = 3;
  // Low pulse length of the interrupt output, in clocks
  localparam logic [1:0] CSC_IRQ_PULSE_CYC = 2'h3;
  // Access kinds for the card cycle
  typedef enum logic [2:0] {
    CSC_ACC_COMMON = 3'b001,
    CSC_ACC_ATTR = 3'b010,
    CSC_ACC_IO = 3'b100
  } csc_acc_t;
  typedef enum logic [2:0] {
    CSC_ST_IDLE = 3'b001,
    CSC_ST_STROBE = 3'b010,
    CSC_ST_DONE = 3'b100
  } csc_state_t;
endpackage : csc_pkg

// File: test/csc_card_model.sv
// Purpose: Behavioural card standing in the slot
// Assumes: Strobe from the device changes on rising clk_i edges
// Notes: Read data is scrambled whenever the card is not strobed
`timescale 1ns/100ps
module csc_card_model (
  // Control from the bench
  input wire logic clk_i,
  input wire logic [1:0] present_i,
  input wire logic [3:0] wait_cyc_i,
  input wire logic [15:0] data_i,
  // Strobe from the device
  input wire logic card_strobe_n_i,
  // Card pins
  output logic card_detect1_n_o,
  output logic card_detect2_n_o,
  output logic wait_n_o,
  output logic [15:0] rdata_o
);
  logic [3:0] wait_q;
  assign card_detect1_n_o = ~present_i[0];
  assign card_detect2_n_o = ~present_i[1];
  always_ff @(posedge clk_i) begin
    if (card_strobe_n_i) begin
      wait_q <= wait_cyc_i;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end
  end
  assign wait_n_o = card_strobe_n_i || (wait_q == 4'h0);
  // Inverted data outside strobes so stale data never matches
  assign rdata_o = card_strobe_n_i ? ~data_i : data_i;
endmodule : csc_card_model

// File: test/csc_slot_ctrl_tb_top.sv
// Purpose: Self-checking bench for the card slot control block
// Assumes: Card model in the slot, bench is the Wishbone master
// Notes: Random data from a fixed-seed xorshift
`timescale 1ns/100ps
module csc_slot_ctrl_tb_top import csc_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rdrv = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0, at = 1'b0, io = 1'b0, rd = 1'b0;
  logic rb = 1'b0, wp = 1'b1, inp = 1'b1, spk = 1'b1, ring = 1'b1, gp = 1'b1, lv, dq;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rdat, r, seed = 32'h0001_7496, wdo;
  logic [1:0] pres = 2'b11;
  logic [3:0] wc = 4'h0;
  logic [15:0] cdat = 16'h0000, crd, rdo, ld;
  logic ack, irq_pulse_out_n, done, b16, rvld, dreq, asel, strb, cd1, cd2, wt, spo, rio, irq, hen, len, pa, pb;
  int fails = 0, comparisons = 0, n;

  always #5 clk_i = ~clk_i;

  csc_slot_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .reset_drive_i(rdrv), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(wdo), .wb_ack_o(ack), .int_o(irq_pulse_out_n),
    .cyc_req_i(req), .cyc_attr_i(at), .cyc_io_i(io), .cyc_rd_i(rd), .cyc_rdata_i(crd), .cyc_done_o(done),
    .cyc_16bit_o(b16), .cyc_rdata_o(rdo), .cyc_rdata_valid_o(rvld), .dma_req_o(dreq),
    .card_detect1_n_i(cd1), .card_detect2_n_i(cd2), .ready_busy_i(rb), .wait_n_i(wt), .write_protect_i(wp),
    .inpack_n_i(inp), .speaker_n_i(spk), .ring_n_i(ring), .attr_sel_n_o(asel), .card_strobe_n_o(strb),
    .volt_detect_gp_input_i(gp), .power_ok_input_i(1'b1), .speaker_pass_out_n_o(spo),
    .ring_indicate_out_n_o(rio), .irq_pulse_out_n_o(irq), .slot_supply_high_en_n_o(hen),
    .slot_supply_low_en_n_o(len), .prog_supply_ctl_a_o(pa), .prog_supply_ctl_b_o(pb));

  csc_card_model card_u (.clk_i(clk_i), .present_i(pres), .wait_cyc_i(wc), .data_i(cdat),
    .card_strobe_n_i(strb), .card_detect1_n_o(cd1), .card_detect2_n_o(cd2), .wait_n_o(wt), .rdata_o(crd));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Expected {5V en_n, 3.3V en_n, vpp vcc, vpp pgm}; 5V wins over 3.3V, vcc level over programming level
  function automatic logic [3:0] exp_sup(input logic [7:0] c);
    return {~c[4], ~(c[5] & ~c[4]), c[6], c[7] & ~c[6]};
  endfunction : exp_sup

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // One classic cycle, released only after ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // Card read cycle; counts strobe cycles and keeps the read result
  task automatic card(input logic a, input logic i, input logic [3:0] w, input logic ea);
    int s;
    s = 0;
    at <= a;
    io <= i;
    rd <= 1'b1;
    wc <= w;
    req <= 1'b1;
    do begin
      @(posedge clk_i);
      if (strb === 1'b0) begin
        s++;
        chk("attr_sel_n", asel, ea);
      end
    end while (done !== 1'b1);
    lv = rvld;
    ld = rdo;
    req <= 1'b0;
    chk("strobe_cycles", s, w + 1);
    @(posedge clk_i);
  endtask : card

  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    end_sim();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("reset_outputs", {irq_pulse_out_n, hen, len, pa, pb, irq, spo, rio, asel}, 9'h0CF);
    for (int k = 0; k < 4; k++) begin
      pres <= k[1:0];
      repeat (3) @(posedge clk_i);
      wb(1'b0, CSC_OFS_STAT, 32'h0);
      chk("status", rdat[5:0], {4'hA, !k[1], k == 3});
    end
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", rdat, 32'h0);
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      r = (k == 0) ? 32'h51 : ((k == 1) ? 32'hA1 : ((k == 2) ? 32'hF1 : {24'h00_0000, r[7:4], 4'h1}));
      wb(1'b1, CSC_OFS_CTRL, r);
      @(posedge clk_i);
      chk("supplies", {hen, len, pa, pb}, exp_sup(r[7:0]));
      wb(1'b0, CSC_OFS_CTRL, 32'h0);
      chk("ctrl", rdat[7:0], r[7:0]);
    end
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      card(k % 3 == 1, k % 3 == 2, {2'b00, r[1:0]}, k % 3 == 0);
    end
    wb(1'b1, CSC_OFS_CTRL, 32'hF5);
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      inp <= k[0];
      wp <= k[1];
      cdat <= r[15:0];
      card(1'b0, 1'b1, 4'h0, 1'b0);
      chk("rdata_valid", lv, !k[0]);
      if (!k[0]) chk("rdata", ld, r[15:0]);
      chk("io_16bit", b16, !k[1]);
    end
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      spk <= r[0];
      ring <= r[1];
      repeat (3) @(posedge clk_i);
      chk("speaker", spo, r[0]);
      chk("ring", rio, r[1]);
    end
    wb(1'b1, CSC_OFS_CTRL, 32'hF7);
    inp <= 1'b0;
    repeat (3) @(posedge clk_i);
    dq = dreq;
    inp <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("dma_from_inpack", dq ^ dreq, 1'b1);
    wb(1'b1, CSC_OFS_CTRL, 32'hF3);
    dq = dreq;
    wp <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("dma_from_wp", dq ^ dreq, 1'b1);
    card(1'b0, 1'b1, 4'h0, 1'b1);
    // DMA cycle held by wait: select turns into the acknowledge
    wc <= 4'h2;
    req <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("dma_ack", asel, 1'b0);
    do begin
      @(posedge clk_i);
    end while (done !== 1'b1);
    req <= 1'b0;
    @(posedge clk_i);
    wb(1'b1, CSC_OFS_MASK, 32'h2);
    for (int k = 1; k >= 0; k--) begin
      wb(1'b1, CSC_OFS_CTRL, {24'h00_0000, 7'h7C, k[0]});
      rb <= k[0];
      repeat (2) @(posedge clk_i);
      wb(1'b1, CSC_OFS_EVT, 32'h7);
      rb <= ~k[0];
      n = 0;
      repeat (8) begin
        @(posedge clk_i);
        if (irq === 1'b0) n++;
      end
      chk("irq_low_cycles", n, 3);
      chk("int_set", irq_pulse_out_n, 1'b1);
      wb(1'b1, CSC_OFS_EVT, 32'h7);
      chk("int_clear", irq_pulse_out_n, 1'b0);
    end
    wb(1'b1, CSC_OFS_MASK, 32'h4);
    pres <= 2'b01;
    repeat (4) @(posedge clk_i);
    chk("int_masked", {irq_pulse_out_n, irq}, 2'b01);
    gp <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, CSC_OFS_EVT, 32'h0);
    chk("events", {irq_pulse_out_n, rdat[2:0]}, 4'hD);
    wb(1'b1, CSC_OFS_CTRL, 32'hF0);
    wb(1'b1, CSC_OFS_EVT, 32'h7);
    gp <= 1'b1;
    repeat (4) @(posedge clk_i);
    wb(1'b0, CSC_OFS_EVT, 32'h0);
    chk("gp_disabled", rdat[2], 1'b0);
    rdrv <= 1'b1;
    @(posedge clk_i);
    rdrv <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, CSC_OFS_CTRL, 32'h0);
    chk("cold_reset", {rdat[7:0], hen, len, pa, pb}, {8'h00, exp_sup(8'h00)});
    end_sim();
  end
endmodule : csc_slot_ctrl_tb_top
